// file: opf_host.sv
// Purpose: Host model issuing one command at a time on the link
// Assumes: Link clock free running; first request after reset release
// Notes:   Released lines show the inverse of the last value, no pull-ups
`timescale 1ns/10ps
module opf_host (
  // Link clock
  input  wire logic        LINK_CLK,
  // Request
  output logic             LINK_REQ,
  output logic             LINK_WR,
  output logic [7:0]       LINK_CODE,
  output logic [15:0]      LINK_WDATA,
  // Answer
  input  wire logic        LINK_DONE,
  input  wire logic        LINK_ERR,
  input  wire logic [15:0] LINK_RDATA
);
  initial begin
    LINK_REQ = 1'b0;
    {LINK_WR, LINK_CODE, LINK_WDATA} = 25'h0;
  end
  // One pulse request, lines held until the answer edge
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] r, output logic e);
    int n;
    n = 0;
    @(negedge LINK_CLK);
    LINK_REQ = 1'b1;
    {LINK_WR, LINK_CODE, LINK_WDATA} = {w, c, d};
    @(negedge LINK_CLK);
    LINK_REQ = 1'b0;
    do begin
      @(posedge LINK_CLK);
      n++;
    end while (LINK_DONE !== 1'b1 && n < 20);
    r = LINK_RDATA;
    e = LINK_ERR;
    // No answer: hand back unknowns so every compare on them fails
    if (LINK_DONE !== 1'b1) begin
      r = 'x;
      e = 1'bx;
    end
    {LINK_WR, LINK_CODE, LINK_WDATA} <= ~{w, c, d};
  endtask
endmodule // opf_host

// file: opf_pkg.sv
// Purpose: Shared constants and types for the over-power fault and status block
// Assumes: Command codes index the registers; link words are up to 16 bits
// Notes:   Reset values of the settings are neutral defaults
package opf_pkg;
  // Command codes of the registers
  localparam logic [7:0]  CODE_FAULT_LIMIT  = 8'h68;
  localparam logic [7:0]  CODE_FAULT_ACTION = 8'h69;
  localparam logic [7:0]  CODE_WARN_LIMIT   = 8'h6A;
  localparam logic [7:0]  CODE_STATUS       = 8'h78;
  // Reset values
  localparam logic [7:0]  ACTION_RESET      = 8'h80;
  localparam logic [15:0] LIMIT_RESET       = 16'hFFFF;
  // Fault action fields
  localparam int          DELAY_LSB         = 0;
  localparam int          RETRY_LSB         = 3;
  localparam int          RESP_LSB          = 6;
  localparam logic [1:0]  RESP_IGNORE       = 2'h0;
  localparam logic [1:0]  RESP_DISABLE      = 2'h2;
  localparam logic [2:0]  RETRY_NONE        = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER     = 3'h7;
  // Summary status bit positions
  localparam int          ST_OFF            = 6;
  localparam int          ST_OV             = 5;
  localparam int          ST_OC             = 4;
  localparam int          ST_UV             = 3;
  localparam int          ST_TEMP           = 2;
  localparam int          ST_CML            = 1;
  localparam int          ST_OTHER          = 0;
  // Restart delay unit
  localparam int          DELAY_UNIT_MS     = 200;
  localparam int          CLK_MHZ           = 200;
  localparam int          UNIT_CYCLES       = DELAY_UNIT_MS * 1000 * CLK_MHZ;

  // One request held across the crossing
  typedef struct packed {
    logic        wr;
    logic [7:0]  code;
    logic [15:0] wdata;
  } link_req_t;

  // Power stage sequencing
  typedef enum logic [1:0] {RUNNING, RETRY_WAIT, LATCHED_OFF, CMD_OFF} pwr_state_t;
endpackage

// file: opf_props.sv
// Purpose: Timing relations of the over-power block at its ports
// Assumes: Bound to the top module; RST clears both domains
// Notes:   Link answers are bounded for a 32 ns link and 5 ns system clock
`timescale 1ns/10ps
module opf_props (
  // Clocks and reset
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        LINK_CLK,
  // Link answer
  input wire logic        LINK_REQ,
  input wire logic        LINK_BUSY,
  input wire logic        LINK_DONE,
  input wire logic        LINK_ERR,
  input wire logic [15:0] LINK_RDATA,
  // Power stage
  input wire logic        ON_CMD,
  input wire logic        BIAS_OK,
  input wire logic        OTHER_SHUTDOWN,
  input wire logic        OUTPUT_ENABLE
);
  // Shutdown causes must remove output within the sync delay
  a_cmd_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    $fell(ON_CMD) |-> ##[1:5] !OUTPUT_ENABLE) else $error("output on after off command");
  a_bias_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    !BIAS_OK |-> ##[1:2] !OUTPUT_ENABLE) else $error("output on without bias");
  a_other_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    OTHER_SHUTDOWN |-> ##[1:2] !OUTPUT_ENABLE) else $error("output on after other fault");
  a_rise_cause: assert property (@(posedge SYS_CLK) disable iff (RST)
    $rose(OUTPUT_ENABLE) |-> $past(BIAS_OK) && !$past(OTHER_SHUTDOWN))
    else $error("output rose while blocked");
  // Link handshake
  a_answer_time: assert property (@(posedge LINK_CLK) disable iff (RST)
    LINK_REQ && !LINK_BUSY |-> ##[2:9] LINK_DONE) else $error("no link answer");
  a_done_pulse: assert property (@(posedge LINK_CLK) disable iff (RST)
    LINK_DONE |=> !LINK_DONE) else $error("done longer than one cycle");
  a_busy_drop: assert property (@(posedge LINK_CLK) disable iff (RST)
    LINK_DONE |=> !LINK_BUSY) else $error("busy after answer");
  a_rdata_hold: assert property (@(posedge LINK_CLK) disable iff (RST)
    $changed(LINK_RDATA) || $changed(LINK_ERR) |-> LINK_DONE) else $error("answer moved");
endmodule // opf_props

// file: over_power_fault_and_status.sv
// Purpose: Over-power fault response, warning compare and summary status byte
// Assumes: Link logic hands one decoded command at a time on its own clock
//          BIAS_OK, POWER_MEAS and the fault events already run on SYS_CLK
// Notes:   Power and limits are mantissas of the same linear exponent
//          Link requests cross by toggle and are answered by toggle
//          Restart delay counts whole units of UNIT_CYCLES system clocks
//
// Functional notes
// - Low three action bits give the restart delay in 200 ms steps.
// - Response 00 ignores an over-power fault; output keeps running.
// - Response 10 disables the output, then follows the retry count.
// - Retry count 000 stays off until the fault is cleared.
// - Counts one to six retry that often, then stay off until cleared.
// - Delay spans start of one restart attempt to the next; the timer here runs from entry into RETRY_WAIT to the restart.
// - Count 111 retries forever until commanded off, bias loss, other fault.
// - Hold a 16-bit warning threshold and compare measured power against it.
// - Warning raised only when power strictly exceeds the threshold.
// - Status bit 6 set whenever the output delivers no power.
// - Status bit 5 reports an output overvoltage fault.
// - Status bit 4 reports an output overcurrent fault.
// - Status bit 3 reports an input undervoltage fault.
// - Status bit 2 reports any temperature fault or warning.
// - Status bit 1 reports communication, memory or logic faults.
// - Status bit 0 reports any other fault or warning.
// - Output on/off never clears the status flags.
// - Hold a fault threshold; exceeding it triggers the fault response.
`timescale 1ns/10ps
module over_power_fault_and_status #(
  parameter int UNIT_CYCLES = opf_pkg::UNIT_CYCLES
) (
  // System clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  // Link side command port
  input  wire logic        LINK_CLK,
  input  wire logic        LINK_REQ,
  input  wire logic        LINK_WR,
  input  wire logic [7:0]  LINK_CODE,
  input  wire logic [15:0] LINK_WDATA,
  output logic             LINK_BUSY,
  output logic             LINK_DONE,
  output logic             LINK_ERR,
  output logic [15:0]      LINK_RDATA,
  // Power stage
  input  wire logic        ON_CMD,
  input  wire logic        BIAS_OK,
  input  wire logic [15:0] POWER_MEAS,
  output logic             OUTPUT_ENABLE,
  // Fault events, same clock as SYS_CLK
  input  wire logic        FAULT_CLEAR,
  input  wire logic        OV_FAULT,
  input  wire logic        OC_FAULT,
  input  wire logic        UV_FAULT,
  input  wire logic        TEMP_EVENT,
  input  wire logic        CML_EVENT,
  input  wire logic        OTHER_EVENT,
  input  wire logic        OTHER_SHUTDOWN
);
  // A unit of zero cycles would leave the restart timer without a terminal count
  if (UNIT_CYCLES < 1) begin : g_unit_check
    $error("UNIT_CYCLES must be at least one");
  end

  // Link domain: capture one request, hold it until the answer returns.
  // The captured word is bundled data: it stands still from the toggle of
  // req_tgl until the answer toggle is back, so the system side may read it
  // once the toggle has passed its synchroniser, without a second crossing.
  opf_pkg::link_req_t link_req;
  logic               req_tgl;
  logic               ack_tgl;
  logic [2:0]         ack_sync;
  wire                ack_edge = ack_sync[2] ^ ack_sync[1];
  wire                take_req = LINK_REQ & ~LINK_BUSY;

  // Requests while busy are dropped; busy tells the link logic to wait
  // Capture and toggle share one edge so the word is ready before the toggle
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      link_req <= '0;
      req_tgl  <= 1'b0;
    end else if (take_req) begin
      link_req <= '{wr: LINK_WR, code: LINK_CODE, wdata: LINK_WDATA};
      req_tgl  <= ~req_tgl;
    end
  end

  // Answer toggle resynchronised; only stage two onward is compared
  // The first stage may go metastable and is read by nothing but stage two
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      ack_sync <= 3'h0;
    end else begin
      ack_sync <= {ack_sync[1:0], ack_tgl};
    end
  end

  // DONE, RDATA and ERR all rise on one link edge, so a host that polls DONE
  // takes the data in the same cycle. BUSY drops on that edge, which lets the
  // next request be taken one cycle after the answer.
  // Answer registers on the link side; held data is stable when the edge shows
  logic [15:0] ans_data;
  logic        ans_err;
  always_ff @(posedge LINK_CLK or posedge RST) begin
    if (RST) begin
      LINK_BUSY  <= 1'b0;
      LINK_DONE  <= 1'b0;
      LINK_ERR   <= 1'b0;
      LINK_RDATA <= 16'h0000;
    end else begin
      LINK_DONE <= ack_edge;
      if (take_req) begin
        LINK_BUSY <= 1'b1;
      end else if (ack_edge) begin
        LINK_BUSY <= 1'b0;
      end
      if (ack_edge) begin
        LINK_RDATA <= ans_data;
        LINK_ERR   <= ans_err;
      end
    end
  end

  // Three stages: two resolve metastability, the third gives the edge compare
  // a settled previous value, so only settled stages ever reach logic.
  // System domain: request toggle synchroniser
  logic [2:0] req_sync;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      req_sync <= 3'h0;
    end else begin
      req_sync <= {req_sync[1:0], req_tgl};
    end
  end
  wire req_edge = req_sync[2] ^ req_sync[1];

  // Register decode
  // Unknown codes match nothing and are answered with an error
  wire hit_flimit = link_req.code == opf_pkg::CODE_FAULT_LIMIT;
  wire hit_action = link_req.code == opf_pkg::CODE_FAULT_ACTION;
  wire hit_wlimit = link_req.code == opf_pkg::CODE_WARN_LIMIT;
  wire hit_status = link_req.code == opf_pkg::CODE_STATUS;
  wire hit_any    = hit_flimit | hit_action | hit_wlimit | hit_status;
  wire wr_ok      = req_edge & link_req.wr;

  // Settings
  // Settings hold their reset values until the host writes them
  logic [7:0]  fault_action;
  logic [15:0] warn_limit;
  logic [15:0] fault_limit;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      fault_action <= opf_pkg::ACTION_RESET;
      warn_limit   <= opf_pkg::LIMIT_RESET;
      fault_limit  <= opf_pkg::LIMIT_RESET;
    end else begin
      if (wr_ok && hit_action) begin
        fault_action <= link_req.wdata[7:0];
      end
      if (wr_ok && hit_wlimit) begin
        warn_limit <= link_req.wdata;
      end
      if (wr_ok && hit_flimit) begin
        fault_limit <= link_req.wdata;
      end
    end
  end

  // Action fields
  // Fields act live, so a new setting applies to the next trip or wait
  wire [1:0] resp      = fault_action[opf_pkg::RESP_LSB +: 2];
  wire [2:0] retries   = fault_action[opf_pkg::RETRY_LSB +: 3];
  wire [2:0] delay_cnt = fault_action[opf_pkg::DELAY_LSB +: 3];

  // Restarts taken since the last clear; only counts one to six are bounded
  logic [2:0] attempts;

  // Control pin is asynchronous to SYS_CLK
  // Two stages before any logic reads the pin
  logic [1:0] on_sync;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      on_sync <= 2'h0;
    end else begin
      on_sync <= {on_sync[0], ON_CMD};
    end
  end

  // Compares; limits and measurement share exponent 3
  // Strict greater-than: a reading equal to a limit never trips it
  wire op_warn  = POWER_MEAS > warn_limit;
  wire op_fault = POWER_MEAS > fault_limit;
  wire trip     = OUTPUT_ENABLE & op_fault & (resp == opf_pkg::RESP_DISABLE);
  wire cmd_off  = ~on_sync[1] | ~BIAS_OK;
  wire out_of_tries = (retries != opf_pkg::RETRY_FOREVER) && (attempts >= retries);
  // Latch off at once when no restart is granted or the budget is spent
  wire no_retry     = retries == opf_pkg::RETRY_NONE;
  wire latch_trip   = no_retry | out_of_tries;

  // The unit counter divides the system clock down to one delay unit; the
  // step counter then counts units up to the delay field. A delay field of
  // zero restarts on the cycle after the wait is entered.
  // Restart timer: unit counter ticks, step counter counts the delay field
  localparam int UW = $clog2(UNIT_CYCLES + 1);
  logic [UW-1:0] unit_cnt;
  logic [2:0]    step_cnt;
  // Terminal count of one delay unit
  wire unit_tick = unit_cnt == UW'(UNIT_CYCLES - 1);
  wire delay_done = (step_cnt == delay_cnt) | (delay_cnt == 3'h0);

  // Off command and bias loss win over every other cause and clear the
  // restart budget; another shutdown latches like a spent retry budget.
  // Sequencer state
  opf_pkg::pwr_state_t state;
  opf_pkg::pwr_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      // Output on; watch for off command, other shutdown and trips
      opf_pkg::RUNNING: begin
        if (cmd_off) begin
          next_state = opf_pkg::CMD_OFF;
        end else if (OTHER_SHUTDOWN) begin
          next_state = opf_pkg::LATCHED_OFF;
        end else if (trip) begin
          // Retry budget spent, or none granted: latch off until cleared
          if (latch_trip) begin
            next_state = opf_pkg::LATCHED_OFF;
          end else begin
            next_state = opf_pkg::RETRY_WAIT;
          end
        end
      end
      // Output off while the restart delay runs; a clear restarts at once
      opf_pkg::RETRY_WAIT: begin
        if (cmd_off) begin
          next_state = opf_pkg::CMD_OFF;
        end else if (OTHER_SHUTDOWN) begin
          next_state = opf_pkg::LATCHED_OFF;
        end else if (FAULT_CLEAR || delay_done) begin
          next_state = opf_pkg::RUNNING;
        end
      end
      // Off until cleared; a shutdown still present holds it here
      opf_pkg::LATCHED_OFF: begin
        if (cmd_off) begin
          next_state = opf_pkg::CMD_OFF;
        end else if (FAULT_CLEAR && !OTHER_SHUTDOWN) begin
          next_state = opf_pkg::RUNNING;
        end
      end
      // Commanded off; a shutdown pending at turn-on keeps the output latched off
      opf_pkg::CMD_OFF: begin
        if (cmd_off) begin
          next_state = opf_pkg::CMD_OFF;
        end else if (OTHER_SHUTDOWN) begin
          next_state = opf_pkg::LATCHED_OFF;
        end else begin
          next_state = opf_pkg::RUNNING;
        end
      end
    endcase
  end

  // A restart is the step from waiting back to running
  wire restart      = (state == opf_pkg::RETRY_WAIT) & (next_state == opf_pkg::RUNNING);
  wire count_try    = restart & (retries != opf_pkg::RETRY_FOREVER);
  wire clear_tries  = FAULT_CLEAR | (next_state == opf_pkg::CMD_OFF);

  // State, output enable and attempt count
  // The output enable is registered from next_state so it moves with the state
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state         <= opf_pkg::CMD_OFF;
      OUTPUT_ENABLE <= 1'b0;
      attempts      <= 3'h0;
    end else begin
      state         <= next_state;
      OUTPUT_ENABLE <= next_state == opf_pkg::RUNNING;
      if (clear_tries) begin
        attempts <= 3'h0;
      end else if (count_try) begin
        attempts <= attempts + 3'h1;
      end
    end
  end

  // Delay timing restarts whenever the wait is entered
  // Leaving the wait for any reason discards partial counts
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      unit_cnt <= '0;
      step_cnt <= 3'h0;
    end else if (state != opf_pkg::RETRY_WAIT) begin
      unit_cnt <= '0;
      step_cnt <= 3'h0;
    end else if (unit_tick) begin
      unit_cnt <= '0;
      step_cnt <= step_cnt + 3'h1;
    end else begin
      unit_cnt <= unit_cnt + UW'(1);
    end
  end

  // Only FAULT_CLEAR empties them; output on and off cycles leave them alone,
  // so a host reading late still sees what happened while the output was off.
  // Sticky status flags; an event in the clearing cycle survives the clear
  logic [5:0] flags;
  wire  [5:0] flag_set;
  assign flag_set[opf_pkg::ST_OV]    = OV_FAULT;
  assign flag_set[opf_pkg::ST_OC]    = OC_FAULT;
  assign flag_set[opf_pkg::ST_UV]    = UV_FAULT;
  assign flag_set[opf_pkg::ST_TEMP]  = TEMP_EVENT;
  assign flag_set[opf_pkg::ST_CML]   = CML_EVENT;
  assign flag_set[opf_pkg::ST_OTHER] = OTHER_EVENT | op_warn | op_fault;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      flags <= 6'h00;
    end else begin
      flags <= flag_set | (flags & {6{~FAULT_CLEAR}});
    end
  end

  // Summary byte: bit 7 constant zero, bit 6 live off state
  // Bit 6 follows the output live instead of latching, so it clears on restart
  wire [7:0] status_byte = {1'b0, ~OUTPUT_ENABLE, flags};

  // Read selection
  // Byte-wide settings read back with a zero high byte
  wire [15:0] rd_sel = hit_flimit ? fault_limit :
                       hit_action ? {8'h00, fault_action} :
                       hit_wlimit ? warn_limit :
                       hit_status ? {8'h00, status_byte} : 16'h0000;

  // Answer held for the link side, then signalled by toggle
  // Writes answer zero data; writes to the status byte and unknown codes set ERR
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ans_data <= 16'h0000;
      ans_err  <= 1'b0;
      ack_tgl  <= 1'b0;
    end else if (req_edge) begin
      ans_data <= link_req.wr ? 16'h0000 : rd_sel;
      ans_err  <= ~hit_any | (link_req.wr & hit_status);
      ack_tgl  <= ~ack_tgl;
    end
  end
endmodule // over_power_fault_and_status

// file: testbench.sv
// Purpose: Scenario bench for the over-power fault and status block
// Assumes: Restart unit shortened to 8 cycles
// Notes:   Inputs change at the falling system clock edge
`timescale 1ns/10ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic SYS_CLK = 0, LINK_CLK = 0, RST = 1, ON_CMD = 0, BIAS_OK = 1, FAULT_CLEAR = 0;
  logic OV_FAULT = 0, OC_FAULT = 0, UV_FAULT = 0, TEMP_EVENT = 0, CML_EVENT = 0;
  logic OTHER_EVENT = 0, OTHER_SHUTDOWN = 0, LINK_REQ, LINK_WR, LINK_BUSY, LINK_DONE;
  logic LINK_ERR, OUTPUT_ENABLE;
  logic [7:0] LINK_CODE;
  logic [15:0] LINK_WDATA, LINK_RDATA, POWER_MEAS = 0;
  int num_errors = 0, tests_run = 0, rises = 0, low_run = 0, last_low = 0, cycles = 0;
  always #2.5 SYS_CLK = ~SYS_CLK;
  // Link clock offset so its edges drift against the system clock
  initial #3 forever #16 LINK_CLK = ~LINK_CLK;
  over_power_fault_and_status #(.UNIT_CYCLES(8)) over_power_fault_and_status_inst (.*);
  opf_host opf_host_inst (.*);
  // Count restarts and the off time before each one
  always @(posedge SYS_CLK) begin
    cycles++;
    if (OUTPUT_ENABLE === 1'b0) low_run++;
    else begin
      if (low_run != 0) begin rises++; last_low = low_run; end
      low_run = 0;
    end
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  task automatic clr();
    FAULT_CLEAR = 1'b1;
    cyc(1);
    FAULT_CLEAR = 1'b0;
    cyc(10);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e, input string nm);
    logic [15:0] r;
    logic er;
    opf_host_inst.xfer(1'b0, c, 16'h0000, r, er);
    cyc(1);
    `CHK(nm, e, r)
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
    logic [15:0] r;
    logic er;
    opf_host_inst.xfer(1'b1, c, d, r, er);
    cyc(1);
    `CHK("write err", e, er)
  endtask
  // Reset values, read-only status and an unmapped code
  task automatic t_regs();
    rd(opf_pkg::CODE_FAULT_ACTION, 16'h0080, "action");
    rd(opf_pkg::CODE_WARN_LIMIT, 16'hFFFF, "warn");
    rd(opf_pkg::CODE_STATUS, 16'h0040, "off");
    wr(opf_pkg::CODE_STATUS, 16'h00FF, 1'b1);
    rd(opf_pkg::CODE_STATUS, 16'h0040, "status ro");
    rd(8'h00, 16'h0000, "unmapped");
  endtask
  // Sticky flags survive output off and on; shutdown causes
  task automatic t_flags();
    ON_CMD = 1'b1;
    cyc(8);
    rd(opf_pkg::CODE_STATUS, 16'h0000, "on");
    for (int i = 0; i < 6; i++) begin
      {OV_FAULT, OC_FAULT, UV_FAULT, TEMP_EVENT, CML_EVENT, OTHER_EVENT} = 6'h01 << i;
      cyc(1);
      {OV_FAULT, OC_FAULT, UV_FAULT, TEMP_EVENT, CML_EVENT, OTHER_EVENT} = 6'h00;
      ON_CMD = 1'b0;
      cyc(8);
      ON_CMD = 1'b1;
      cyc(8);
      rd(opf_pkg::CODE_STATUS, 16'((2 << i) - 1), "flags");
    end
    clr();
    rd(opf_pkg::CODE_STATUS, 16'h0000, "cleared");
    BIAS_OK = 1'b0;
    cyc(3);
    `CHK("bias off", 1'b0, OUTPUT_ENABLE)
    BIAS_OK = 1'b1;
    OTHER_SHUTDOWN = 1'b1;
    cyc(1);
    OTHER_SHUTDOWN = 1'b0;
    cyc(20);
    `CHK("other off", 1'b0, OUTPUT_ENABLE)
    clr();
  endtask
  // Warning trips only above the limit
  task automatic t_warn();
    wr(opf_pkg::CODE_WARN_LIMIT, 16'h1864, 1'b0);
    POWER_MEAS = 16'h1864;
    cyc(4);
    rd(opf_pkg::CODE_STATUS, 16'h0000, "at limit");
    POWER_MEAS = 16'h1865;
    cyc(4);
    rd(opf_pkg::CODE_STATUS, 16'h0001, "over limit");
    POWER_MEAS = 16'h0000;
    clr();
  endtask
  // Fault response with a held overload; one-unit restart delay
  task automatic t_retry(input logic [1:0] rs, input logic [2:0] n, input int e);
    wr(opf_pkg::CODE_FAULT_ACTION, {8'h00, rs, n, 3'h1}, 1'b0);
    rises = 0;
    POWER_MEAS = 16'h1865;
    cyc(150);
    `CHK("restarts", e, (n == 3'h7) ? int'(rises > 6) : rises)
    if (rises > 0) `CHK("gap", 1'b1, last_low >= 8 && last_low <= 10)
    if (n != 3'h7) `CHK("held", rs == 2'h0, OUTPUT_ENABLE)
    POWER_MEAS = 16'h0000;
    clr();
    `CHK("resume", 1'b1, OUTPUT_ENABLE)
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    cyc(4);
    RST = 1'b0;
    t_regs();
    t_flags();
    t_warn();
    wr(opf_pkg::CODE_FAULT_LIMIT, 16'h1864, 1'b0);
    t_retry(2'h0, 3'h2, 0);
    t_retry(2'h2, 3'h0, 0);
    t_retry(2'h2, 3'h2, 2);
    t_retry(2'h2, 3'h2, 2);
    t_retry(2'h2, 3'h7, 1);
    end_of_test();
  end
endmodule // testbench
bind over_power_fault_and_status opf_props opf_props_inst (.*);
